// File: ipc_pkg.sv
package ipc_pkg;
    localparam int N_NODES = 96;
    localparam int N_CH = 8;
    localparam int N_TRAP = 8;
    localparam int N_HWTRAP = 6;
    localparam int N_GATE = 4;
    localparam int N_ESR = 3;
    localparam int SHR_BASE = 88;
    localparam int ROUT_BASE = 92;
    // node control fields
    localparam int NC_W = 10;
    localparam int NC_REQ = 0;
    localparam int NC_EN = 1;
    localparam int NC_PRIO = 2;
    localparam int NC_PEC = 6;
    localparam int NC_CH = 7;
    // channel control fields
    localparam int CC_W = 12;
    localparam int CC_CNT = 0;
    localparam int CC_BYTE = 8;
    localparam int CC_ISRC = 9;
    localparam int CC_IDST = 10;
    localparam int CC_CONT = 11;
    // byte offsets
    localparam logic [11:0] OFF_NODE_END = 12'h180;
    localparam logic [4:0] OFF_CH_HI = 5'h04;
    localparam logic [11:0] OFF_SSEL = 12'h300;
    localparam logic [11:0] OFF_RCFG = 12'h304;
    localparam logic [11:0] OFF_GCFG = 12'h308;
    localparam logic [11:0] OFF_TFR = 12'h30c;
    localparam logic [11:0] OFF_STAT = 12'h310;
    // reset values
    localparam logic [NC_W-1:0] RST_NODE = 10'h000;
    localparam logic [CC_W-1:0] RST_CCTL = 12'h000;
    localparam logic [15:0] RST_PTR = 16'h0000;
    // service timing in cpu clocks and interrupt vector base
    localparam logic [3:0] LAT_JC = 4'h7;
    localparam logic [3:0] LAT_NOJC = 4'hb;
    localparam logic [7:0] VEC_INT_BASE = 8'h10;
    // gate modes
    localparam logic [1:0] GM_OFF = 2'h0;
    localparam logic [1:0] GM_ON = 2'h1;
    localparam logic [1:0] GM_MATCH = 2'h2;
    localparam logic [1:0] GM_MISS = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BUSY = 2'b11
    } ipc_state_t;
endpackage

// File: ipc_router.sv
`timescale 1ns/1ps
module ipc_router #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pins and configuration
    input wire logic [N-1:0] pin_i,
    input wire logic [2*N-1:0] edge_cfg_i,
    input wire logic [N-1:0] pattern_i,
    input wire logic [4*N-1:0] gate_cfg_i,
    // gated events
    output logic [N-1:0] evt_o
);
    logic [N-1:0] s1_q, s2_q, s3_q, evt_q, det, pass_g, evt_d;
    wire rise_any = |(s2_q & ~s3_q);
    wire match = (s2_q == pattern_i);

    for (genvar i = 0; i < N; i++) begin : g_ch
        assign det[i] = (s2_q[i] & ~s3_q[i] & edge_cfg_i[2*i]) |
                        (~s2_q[i] & s3_q[i] & edge_cfg_i[2*i+1]);
        wire [1:0] sel = gate_cfg_i[4*i +: 2];
        wire [1:0] mode = gate_cfg_i[4*i+2 +: 2];
        assign pass_g[i] = (mode == ipc_pkg::GM_ON) |
                           ((mode == ipc_pkg::GM_MATCH) & match) |
                           ((mode == ipc_pkg::GM_MISS) & ~match);
        assign evt_d[i] = det[sel] & pass_g[i];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            evt_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            evt_q <= evt_d;
        end
    end
    assign evt_o = evt_q;

    property p_rise_pass;
        @(posedge clk_i) disable iff (!rst_n_i)
        (s2_q[0] && !s3_q[0] && edge_cfg_i[0] && gate_cfg_i[3:0] == 4'h4)
            |=> evt_o[0];
    endproperty
    a_rise_pass: assert property (p_rise_pass)
        else $error("rising edge not passed to gate 0");
    property p_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        !rise_any && (s2_q == s3_q) |=> evt_o == '0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("gate event without any input edge");
endmodule

// File: ipc_ctrl.sv
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - each node selects standard interrupt or peripheral event transfer service
// - standard service suspends program and fetches the node's vector
// - an event transfer steals exactly one cycle, no branch or context change
// - transfer moves a byte or word, then bumps source, destination or both
// - transfer counter decrements per transfer unless continuous mode is set
// - counter reaching zero turns the owning node into a standard interrupt
// - eight transfer channels, each with own pointers and counter
// - request to service start takes 7 clocks with jump cache, else 11
// - 96 nodes, each with request flag, enable flag and priority
// - shared nodes take their request from a software selected source
// - router has 4 edge channels, a routing matrix and 4 output gates
// - each router channel detects rising, falling or both edges
// - each gate passes events on a programmable pattern match or miss
// - a hardware trap branches at once to its own vector
// - every hardware trap and system request trap sets its own bit in the trap flag register
// - a trap preempts everything except a trap of equal or higher priority in service
// - during trap service interrupts and event transfers are not accepted
// - three service request pins, two of them raise system request traps
// - a software trap enters vectored service for its trap number
// - software setting a request flag raises the node like hardware
module ipc_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // request sources
    input wire logic [ipc_pkg::N_NODES-1:0] periph_req_i,
    input wire logic [3:0] alt_req_i,
    input wire logic [3:0] ext_req_pin_i,
    input wire logic [ipc_pkg::N_ESR-1:0] esr_pin_i,
    input wire logic [ipc_pkg::N_HWTRAP-1:0] hw_trap_i,
    // cpu core side
    input wire logic [3:0] cpu_prio_i,
    input wire logic jump_cache_i,
    input wire logic svc_done_i,
    input wire logic sw_trap_i,
    input wire logic [7:0] sw_trap_num_i,
    output logic svc_start_o,
    output logic [7:0] svc_vec_o,
    output logic svc_trap_o,
    // event transfer side
    output logic pec_steal_o,
    output logic [15:0] pec_src_o,
    output logic [15:0] pec_dst_o,
    output logic pec_byte_o
);
    logic [ipc_pkg::NC_W-1:0] node_q [ipc_pkg::N_NODES];
    logic [15:0] src_q [ipc_pkg::N_CH];
    logic [15:0] dst_q [ipc_pkg::N_CH];
    logic [ipc_pkg::CC_W-1:0] cctl_q [ipc_pkg::N_CH];
    logic [3:0] ssel_q;
    logic [11:0] rcfg_q;
    logic [15:0] gcfg_q;
    logic [ipc_pkg::N_TRAP-1:0] tfr_q, tpend_q;
    logic trap_act_q;
    logic [2:0] tlvl_q;
    logic sw_pend_q;
    logic [7:0] sw_num_q;
    ipc_pkg::ipc_state_t st_q;
    logic [3:0] cnt_q;
    logic [2:0] esr_s1_q, esr_s2_q, esr_s3_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic start_q, trap_q, steal_q, pbyte_q;
    logic [7:0] vec_q;
    logic [15:0] psrc_q, pdst_q;
    logic [3:0] rout_evt;

    function automatic logic [3:0] nprio(input logic [ipc_pkg::NC_W-1:0] nc);
        nprio = nc[ipc_pkg::NC_PRIO +: 4];
    endfunction

    // apb decode
    wire [6:0] a_idx = paddr_i[8:2];
    wire [2:0] a_ch = paddr_i[6:4];
    wire [1:0] a_reg = paddr_i[3:2];
    wire is_node = paddr_i < ipc_pkg::OFF_NODE_END;
    wire is_ch = (paddr_i[11:7] == ipc_pkg::OFF_CH_HI) && (a_reg != 2'h3);
    wire is_ssel = paddr_i == ipc_pkg::OFF_SSEL;
    wire is_rcfg = paddr_i == ipc_pkg::OFF_RCFG;
    wire is_gcfg = paddr_i == ipc_pkg::OFF_GCFG;
    wire is_tfr = paddr_i == ipc_pkg::OFF_TFR;
    wire is_stat = paddr_i == ipc_pkg::OFF_STAT;
    wire hit = is_node | is_ch | is_ssel | is_rcfg | is_gcfg | is_tfr | is_stat;
    wire setup = psel_i & ~penable_i;
    wire wr = psel_i & penable_i & pwrite_i & pready_q & ~pslverr_q;
    wire [31:0] rd_node = is_node ? {22'h0, node_q[a_idx]} : 32'h0;
    wire [31:0] rd_ch = (a_reg == 2'h0) ? {16'h0, src_q[a_ch]} :
                        (a_reg == 2'h1) ? {16'h0, dst_q[a_ch]} : {20'h0, cctl_q[a_ch]};
    wire [7:0] stat = {esr_s2_q[2], sw_pend_q, trap_act_q, st_q, tlvl_q};
    wire [31:0] rdata = is_node ? rd_node :
                        is_ch ? rd_ch :
                        is_ssel ? {28'h0, ssel_q} :
                        is_rcfg ? {20'h0, rcfg_q} :
                        is_gcfg ? {16'h0, gcfg_q} :
                        is_tfr ? {24'h0, tfr_q} :
                        is_stat ? {24'h0, stat} : 32'h0;

    // request sources per node
    wire [3:0] shr = (ssel_q & alt_req_i) |
                     (~ssel_q & periph_req_i[ipc_pkg::SHR_BASE +: 4]);
    wire [ipc_pkg::N_NODES-1:0] src_req = {periph_req_i[ipc_pkg::ROUT_BASE +: 4] | rout_evt,
                                           shr, periph_req_i[ipc_pkg::SHR_BASE-1:0]};

    ipc_router #(
        .N(ipc_pkg::N_GATE)
    ) u_rout (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(ext_req_pin_i),
        .edge_cfg_i(rcfg_q[7:0]),
        .pattern_i(rcfg_q[11:8]),
        .gate_cfg_i(gcfg_q),
        .evt_o(rout_evt)
    );

    // arbitration among enabled pending nodes
    logic best_v;
    logic [6:0] best_i;
    logic [3:0] best_p;
    always_comb begin
        best_v = 1'b0;
        best_i = 7'h00;
        best_p = 4'h0;
        for (int n = 0; n < ipc_pkg::N_NODES; n++) begin
            if (node_q[n][ipc_pkg::NC_REQ] && node_q[n][ipc_pkg::NC_EN] &&
                (!best_v || nprio(node_q[n]) > best_p)) begin
                best_v = 1'b1;
                best_i = 7'(n);
                best_p = nprio(node_q[n]);
            end
        end
    end
    wire [2:0] bch = node_q[best_i][ipc_pkg::NC_CH +: 3];
    wire [7:0] bcnt = cctl_q[bch][ipc_pkg::CC_CNT +: 8];
    wire bcont = cctl_q[bch][ipc_pkg::CC_CONT];
    wire bbyte = cctl_q[bch][ipc_pkg::CC_BYTE];
    wire best_pec = node_q[best_i][ipc_pkg::NC_PEC] & (bcont | (bcnt != 8'h00));
    wire pec_last = ~bcont & (bcnt == 8'h01);
    wire [15:0] step = bbyte ? 16'h0001 : 16'h0002;
    wire above = best_v & (best_p > cpu_prio_i);

    // trap selection, lowest index first
    wire [ipc_pkg::N_TRAP-1:0] trap_ev = {esr_s2_q[1:0] & ~esr_s3_q[1:0], hw_trap_i};
    logic [2:0] tp;
    always_comb begin
        tp = 3'h0;
        for (int t = ipc_pkg::N_TRAP - 1; t >= 0; t--) begin
            if (tpend_q[t]) begin
                tp = 3'(t);
            end
        end
    end
    wire trap_hit = (|tpend_q) & (~trap_act_q | (tp < tlvl_q));
    wire idle = st_q == ipc_pkg::ST_IDLE;
    wire free = ~trap_act_q & ~trap_hit;
    wire take_sw = idle & free & sw_pend_q;
    wire take_int = idle & free & ~sw_pend_q & above & ~best_pec;
    wire take_pec = (st_q != ipc_pkg::ST_WAIT) & free & above & best_pec;
    wire [3:0] lat_ld = jump_cache_i ? 4'(ipc_pkg::LAT_JC - 4'h2) :
                                       4'(ipc_pkg::LAT_NOJC - 4'h2);
    wire [ipc_pkg::N_TRAP-1:0] tclr = {{(ipc_pkg::N_TRAP-1){1'b0}}, trap_hit} << tp;
    wire [ipc_pkg::N_TRAP-1:0] tfr_w1c = (wr & is_tfr) ? pwdata_i[7:0] : 8'h00;

    // apb response
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q <= (setup & ~pwrite_i) ? rdata : prdata_q;
        end
    end

    // node control registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int n = 0; n < ipc_pkg::N_NODES; n++) begin
                node_q[n] <= ipc_pkg::RST_NODE;
            end
        end else begin
            for (int n = 0; n < ipc_pkg::N_NODES; n++) begin
                if (wr && is_node && a_idx == 7'(n)) begin
                    node_q[n] <= pwdata_i[ipc_pkg::NC_W-1:0];
                end else if (best_i == 7'(n) && (take_int || (take_pec && !pec_last))) begin
                    node_q[n][ipc_pkg::NC_REQ] <= 1'b0;
                end
                if (src_req[n]) begin
                    node_q[n][ipc_pkg::NC_REQ] <= 1'b1;
                end
            end
        end
    end

    // event transfer channels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < ipc_pkg::N_CH; c++) begin
                src_q[c] <= ipc_pkg::RST_PTR;
                dst_q[c] <= ipc_pkg::RST_PTR;
                cctl_q[c] <= ipc_pkg::RST_CCTL;
            end
        end else begin
            for (int c = 0; c < ipc_pkg::N_CH; c++) begin
                if (take_pec && bch == 3'(c)) begin
                    if (cctl_q[c][ipc_pkg::CC_ISRC]) begin
                        src_q[c] <= src_q[c] + step;
                    end
                    if (cctl_q[c][ipc_pkg::CC_IDST]) begin
                        dst_q[c] <= dst_q[c] + step;
                    end
                    if (!bcont) begin
                        cctl_q[c][ipc_pkg::CC_CNT +: 8] <= bcnt - 8'h01;
                    end
                end else if (wr && is_ch && a_ch == 3'(c)) begin
                    if (a_reg == 2'h0) begin
                        src_q[c] <= pwdata_i[15:0];
                    end else if (a_reg == 2'h1) begin
                        dst_q[c] <= pwdata_i[15:0];
                    end else begin
                        cctl_q[c] <= pwdata_i[ipc_pkg::CC_W-1:0];
                    end
                end
            end
        end
    end

    // configuration, trap flags and pin synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ssel_q <= 4'h0;
            rcfg_q <= 12'h000;
            gcfg_q <= 16'h0000;
            tfr_q <= 8'h00;
            tpend_q <= 8'h00;
            sw_pend_q <= 1'b0;
            sw_num_q <= 8'h00;
            esr_s1_q <= 3'h0;
            esr_s2_q <= 3'h0;
            esr_s3_q <= 3'h0;
        end else begin
            ssel_q <= (wr && is_ssel) ? pwdata_i[3:0] : ssel_q;
            rcfg_q <= (wr && is_rcfg) ? pwdata_i[11:0] : rcfg_q;
            gcfg_q <= (wr && is_gcfg) ? pwdata_i[15:0] : gcfg_q;
            tfr_q <= (tfr_q & ~tfr_w1c) | trap_ev;
            tpend_q <= (tpend_q & ~tclr) | trap_ev;
            sw_pend_q <= sw_trap_i | (sw_pend_q & ~take_sw);
            sw_num_q <= sw_trap_i ? sw_trap_num_i : sw_num_q;
            esr_s1_q <= esr_pin_i;
            esr_s2_q <= esr_s1_q;
            esr_s3_q <= esr_s2_q;
        end
    end

    // service sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ipc_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            vec_q <= 8'h00;
            trap_q <= 1'b0;
            trap_act_q <= 1'b0;
            tlvl_q <= 3'h0;
        end else if (trap_hit) begin
            st_q <= ipc_pkg::ST_WAIT;
            cnt_q <= lat_ld;
            vec_q <= {5'h00, tp};
            trap_q <= 1'b1;
            trap_act_q <= 1'b1;
            tlvl_q <= tp;
        end else begin
            unique case (st_q)
                ipc_pkg::ST_IDLE: begin
                    if (take_sw || take_int) begin
                        st_q <= ipc_pkg::ST_WAIT;
                        cnt_q <= lat_ld;
                        trap_q <= 1'b0;
                        vec_q <= take_sw ? sw_num_q : ipc_pkg::VEC_INT_BASE + {1'b0, best_i};
                    end
                end
                ipc_pkg::ST_WAIT: begin
                    if (cnt_q == 4'h0) begin
                        st_q <= ipc_pkg::ST_BUSY;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ipc_pkg::ST_BUSY: begin
                    if (svc_done_i) begin
                        st_q <= ipc_pkg::ST_IDLE;
                        trap_act_q <= 1'b0;
                    end
                end
                default: st_q <= ipc_pkg::ST_IDLE;
            endcase
        end
    end

    // core and transfer outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_q <= 1'b0;
            steal_q <= 1'b0;
            psrc_q <= 16'h0000;
            pdst_q <= 16'h0000;
            pbyte_q <= 1'b0;
        end else begin
            start_q <= (st_q == ipc_pkg::ST_WAIT) && (cnt_q == 4'h0) && !trap_hit;
            steal_q <= take_pec;
            psrc_q <= take_pec ? src_q[bch] : psrc_q;
            pdst_q <= take_pec ? dst_q[bch] : pdst_q;
            pbyte_q <= take_pec ? bbyte : pbyte_q;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign svc_start_o = start_q;
    assign svc_vec_o = vec_q;
    assign svc_trap_o = trap_q;
    assign pec_steal_o = steal_q;
    assign pec_src_o = psrc_q;
    assign pec_dst_o = pdst_q;
    assign pec_byte_o = pbyte_q;

    property p_pec_one;
        @(posedge clk_i) disable iff (!rst_n_i)
        pec_steal_o && !$past(take_pec) |-> 1'b0;
    endproperty
    a_pec_one: assert property (p_pec_one)
        else $error("transfer steal without a taken request");
    property p_lat_jc;
        @(posedge clk_i) disable iff (!rst_n_i || trap_hit)
        (take_int || take_sw) && jump_cache_i |=> !svc_start_o[*6] ##1 svc_start_o;
    endproperty
    a_lat_jc: assert property (p_lat_jc)
        else $error("service start not 7 clocks after request with jump cache");
    property p_lat_nojc;
        @(posedge clk_i) disable iff (!rst_n_i || trap_hit)
        (take_int || take_sw) && !jump_cache_i |-> ##11 svc_start_o;
    endproperty
    a_lat_nojc: assert property (p_lat_nojc)
        else $error("service start not 11 clocks after request without jump cache");
    property p_cnt;
        @(posedge clk_i) disable iff (!rst_n_i)
        take_pec |=> cctl_q[$past(bch)][7:0] == ($past(bcont) ? $past(bcnt) : $past(bcnt) - 8'h01);
    endproperty
    a_cnt: assert property (p_cnt)
        else $error("transfer counter update wrong");
    property p_ptr;
        @(posedge clk_i) disable iff (!rst_n_i)
        take_pec && cctl_q[bch][ipc_pkg::CC_ISRC] |=> src_q[$past(bch)] == $past(src_q[bch]) + $past(step);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("source pointer not advanced by transfer size");
    property p_tfr;
        @(posedge clk_i) disable iff (!rst_n_i)
        |trap_ev |=> (tfr_q & $past(trap_ev)) == $past(trap_ev);
    endproperty
    a_tfr: assert property (p_tfr)
        else $error("trap flag not set by trap event");
    property p_trap_block;
        @(posedge clk_i) disable iff (!rst_n_i)
        trap_act_q |=> !pec_steal_o && !(st_q == ipc_pkg::ST_WAIT && !svc_trap_o);
    endproperty
    a_trap_block: assert property (p_trap_block)
        else $error("request accepted during trap service");
    property p_prio;
        @(posedge clk_i) disable iff (!rst_n_i)
        take_int || take_pec |-> best_p > cpu_prio_i;
    endproperty
    a_prio: assert property (p_prio)
        else $error("request accepted at or below cpu priority");
    property p_swreq;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr && is_node && pwdata_i[0] |=> node_q[$past(a_idx)][ipc_pkg::NC_REQ];
    endproperty
    a_swreq: assert property (p_swreq)
        else $error("software request flag write not taken");
endmodule

// File: ipc_cpu_model.sv
`timescale 1ns/1ps
module ipc_cpu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // service handshake
    input wire logic svc_start_i,
    input wire logic [7:0] dly_i,
    output logic svc_done_o
);
    logic [7:0] cnt_q;
    logic busy_q;
    // return from service dly_i + 1 cycles after entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            busy_q <= 1'h0;
            svc_done_o <= 1'h0;
        end else begin
            svc_done_o <= busy_q && !svc_start_i && (cnt_q == 8'h00);
            if (svc_start_i) begin
                busy_q <= 1'h1;
                cnt_q <= dly_i;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'h0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [95:0] preq = '0;
    logic [3:0] alt_req = 4'h0, ext_pin = 4'h0, cpu_prio = 4'h0;
    logic [2:0] ext_service_request_pin = 3'h0;
    logic [5:0] hw_trap = 6'h00;
    logic jc = 1'h1, sw_trap = 1'h0, pready, pslverr, rerr;
    logic [7:0] sw_num = 8'h00, dly = 8'h04, svc_vec;
    logic svc_done, svc_start, svc_trap, pec_steal, pec_byte;
    logic [15:0] pec_src, pec_dst;
    int num_errors = 0, comparisons = 0, n;
    always #4 clk = ~clk;
    ipc_ctrl uut (.clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .periph_req_i(preq), .alt_req_i(alt_req),
        .ext_req_pin_i(ext_pin), .esr_pin_i(ext_service_request_pin), .hw_trap_i(hw_trap), .cpu_prio_i(cpu_prio),
        .jump_cache_i(jc), .svc_done_i(svc_done), .sw_trap_i(sw_trap),
        .sw_trap_num_i(sw_num), .svc_start_o(svc_start), .svc_vec_o(svc_vec),
        .svc_trap_o(svc_trap), .pec_steal_o(pec_steal), .pec_src_o(pec_src),
        .pec_dst_o(pec_dst), .pec_byte_o(pec_byte));
    ipc_cpu_model cpu (.clk_i(clk), .rst_n_i(rst_n), .svc_start_i(svc_start),
        .dly_i(dly), .svc_done_o(svc_done));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic fail();
        num_errors++;
        $display("ERROR %0t: wait ran out", $time);
        complete_run();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
        end
        if (i == 16) fail();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'h1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'h0, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic wait_sig(input int sel, input int lim);
        logic s;
        n = 0;
        s = 1'h0;
        while (s !== 1'h1 && n <= lim) begin
            @(posedge clk);
            n++;
            s = (sel == 0) ? svc_start : (sel == 1) ? pec_steal : svc_done;
        end
    endtask
    task automatic need(input int sel);
        wait_sig(sel, 80);
        if (n > 80) fail();
    endtask
    task pulse(input int k);
        preq[k] <= 1'h1;
        @(posedge clk);
        preq[k] <= 1'h0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(12'h014, 32'h0);
        wr(12'h014, 32'h0000000e);
        rd(12'h014, 32'h0000000e);
        rd(12'h3f0, 32'h0);
        chk(32'(rerr), 32'h1);
        $display("test registers done");
        wr(12'h014, 32'h0000000f);
        wait_sig(0, 20);
        chk(n, 32'(ipc_pkg::LAT_JC));
        chk(svc_vec, 32'h15);
        need(2);
        jc <= 1'h0;
        wr(12'h014, 32'h0000000f);
        wait_sig(0, 20);
        chk(n, 32'(ipc_pkg::LAT_NOJC));
        need(2);
        cpu_prio <= 4'h5;
        wr(12'h018, 32'h0000000f);
        wait_sig(0, 20);
        chk(n, 32'h15);
        cpu_prio <= 4'h2;
        need(0);
        chk(svc_vec, 32'h16);
        need(2);
        $display("test interrupts done");
        wr(12'h200, 32'h00001000);
        wr(12'h204, 32'h00002000);
        wr(12'h208, 32'h00000602);
        wr(12'h028, 32'h0000004e);
        pulse(10);
        need(1);
        chk(pec_src, 32'h1000);
        chk(pec_dst, 32'h2000);
        chk(pec_byte, 32'h0);
        @(posedge clk);
        chk(pec_steal, 32'h0);
        wait_sig(0, 12);
        chk(n, 32'hd);
        rd(12'h200, 32'h00001002);
        rd(12'h204, 32'h00002002);
        rd(12'h208, 32'h00000601);
        pulse(10);
        need(1);
        need(0);
        chk(svc_vec, 32'h1a);
        need(2);
        wr(12'h270, 32'h00003000);
        wr(12'h278, 32'h00000b03);
        wr(12'h02c, 32'h000003ce);
        pulse(11);
        need(1);
        chk(pec_src, 32'h3000);
        chk(pec_byte, 32'h1);
        rd(12'h270, 32'h00003001);
        rd(12'h274, 32'h0);
        rd(12'h278, 32'h00000b03);
        $display("test transfers done");
        dly <= 8'h28;
        hw_trap[2] <= 1'h1;
        @(posedge clk);
        hw_trap[2] <= 1'h0;
        need(0);
        chk(svc_vec, 32'h02);
        chk(svc_trap, 32'h1);
        wr(12'h014, 32'h0000000f);
        wait_sig(0, 20);
        chk(n, 32'h15);
        need(0);
        chk(svc_vec, 32'h15);
        dly <= 8'h04;
        need(2);
        rd(12'h30c, 32'h00000004);
        wr(12'h30c, 32'h00000004);
        rd(12'h30c, 32'h0);
        sw_num <= 8'h21;
        sw_trap <= 1'h1;
        @(posedge clk);
        sw_trap <= 1'h0;
        need(0);
        chk(svc_vec, 32'h21);
        chk(svc_trap, 32'h0);
        need(2);
        ext_service_request_pin[0] <= 1'h1;
        need(0);
        chk(svc_vec, 32'h06);
        need(2);
        rd(12'h30c, 32'h00000040);
        $display("test traps done");
        wr(12'h300, 32'h00000001);
        wr(12'h160, 32'h0000000c);
        pulse(88);
        rd(12'h160, 32'h0000000c);
        alt_req[0] <= 1'h1;
        @(posedge clk);
        alt_req[0] <= 1'h0;
        rd(12'h160, 32'h0000000d);
        wr(12'h304, 32'h00000103);
        wr(12'h308, 32'h00000004);
        wr(12'h170, 32'h0000000e);
        ext_pin[0] <= 1'h1;
        need(0);
        chk(svc_vec, 32'h6c);
        need(2);
        wr(12'h308, 32'h00000008);
        ext_pin[0] <= 1'h0;
        wait_sig(0, 20);
        chk(n, 32'h15);
        ext_pin[0] <= 1'h1;
        need(0);
        chk(svc_vec, 32'h6c);
        need(2);
        $display("test router done");
        complete_run();
    end
endmodule
